// ### rtl/ulm_uart.sv
// UART framing, line and modem control and status with flip-flop FIFOs
//
// What this block does
// - Break field one drives serial output low until cleared, except in loopback.
// - Fixed parity sends and checks 0 when even select is one, else 1.
// - Parity enabled gives even parity if even select is one, odd otherwise.
// - Parity enable and even select writes are ignored while busy.
// - Outside nine-bit mode, parity enable turns parity generation and checking on or off.
// - Stop field: one, 1.5 for 5 bits or two stop bits; receiver checks one.
// - Outside nine-bit mode, length field 00..11 selects 5 to 8 data bits both directions.
// - Auto flow control acts only with FIFOs on and auto flow field set.
// - Loopback holds serial output high and routes transmit data to receiver.
// - Loopback disconnects modem inputs and feeds modem outputs back.
// - rts_n low when request field set; forced high at or above receive trigger in auto flow.
// - Loopback holds rts_n high, request field looped to clear-to-send.
// - Nine-bit mode flags address characters at the head; status read clears.
// - Receive FIFO error flag high while FIFOs are on and any entry holds an error.
// - Transmitter empty when shifter and FIFO or holding are empty; resets one.
// - Holding-empty flag shows FIFO full in programmable empty mode with FIFOs.
// - Long low input sets break, framing and parity flags, carried with character.
// - Missing stop sets framing error and resynchronises; status read clears flags.
// - Overrun flag; buffer overwritten without FIFO, new character lost when full.
// - Data ready while a character is held; clears on read or empty FIFO.
// - Clear-to-send bit is inverse of cts_n, request field in loopback, resets one.
// - Delta clear-to-send sets on change and after reset if asserted; read clears.
`timescale 1ns/1ps
`default_nettype none

module ulm_uart (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port
  input wire ulm_pkg::ulm_bus_req_t bus_in,
  output logic [31:0] rdata_out,
  // Serial line and handshake
  input wire logic sin_in,
  input wire logic cts_n_in,
  output logic sout_out,
  output logic rts_n_out
);
  import ulm_pkg::*;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulm_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} ulm_rx_state_t;

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] line_ctrl;
  logic [5:0] modem_ctrl;
  logic [4:0] scratch_field;
  logic fifo_en;
  logic [1:0] rx_trig;
  logic [15:0] divisor;
  logic nine_bit;
  logic prog_empty;

  // Address decode
  wire wr_data = bus_in.wr && (bus_in.addr == ULM_DATA_ADDR);
  wire rd_data = bus_in.rd && (bus_in.addr == ULM_DATA_ADDR);
  wire wr_fifo = bus_in.wr && (bus_in.addr == ULM_FIFO_CTRL_ADDR);
  wire wr_line = bus_in.wr && (bus_in.addr == ULM_LINE_CTRL_ADDR);
  wire wr_modem = bus_in.wr && (bus_in.addr == ULM_MODEM_CTRL_ADDR);
  wire rd_lstat = bus_in.rd && (bus_in.addr == ULM_LINE_STAT_ADDR);
  wire rd_mstat = bus_in.rd && (bus_in.addr == ULM_MODEM_STAT_ADDR);
  wire wr_scratch = bus_in.wr && (bus_in.addr == ULM_SCRATCH_ADDR);
  wire wr_ext = bus_in.wr && (bus_in.addr == ULM_EXT_CTRL_ADDR);

  // Field views
  wire break_ctrl = line_ctrl[ULM_LC_BREAK];
  wire fixed_parity = line_ctrl[ULM_LC_FIXED_PAR];
  wire even_select = line_ctrl[ULM_LC_EVEN];
  wire parity_enable = line_ctrl[ULM_LC_PAR_EN];
  wire two_stop = line_ctrl[ULM_LC_STOP];
  wire [1:0] char_length_sel = line_ctrl[1:0];
  wire loopback_ctrl = modem_ctrl[ULM_MC_LOOPBACK];
  wire rts_field = modem_ctrl[ULM_MC_RTS];
  wire auto_flow_on = fifo_en && modem_ctrl[ULM_MC_AUTO_FLOW];
  wire busy;
  wire fifo_en_change = wr_fifo && (bus_in.wdata[ULM_FC_ENABLE] != fifo_en);

  // Data length shared by both directions; stop length used by transmit only
  wire [3:0] nbits = nine_bit ? 4'h9 : 4'h5 + {2'h0, char_length_sel};
  wire [5:0] stop_ticks = !two_stop ? ULM_BIT_TICKS :
                          (char_length_sel == 2'h0) ? ULM_STOP15_TICKS : ULM_STOP2_TICKS;

  // Parity over the active data bits
  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic ev, input logic fx);
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < 9; k++) begin
      if (k < int'(n)) begin
        acc = acc ^ d[k];
      end
    end
    if (fx) begin
      par_of = !ev;
    end else begin
      par_of = ev ? acc : !acc;
    end
  endfunction : par_of

  // Writes; parity fields are locked while a character is in flight
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      line_ctrl <= 8'h00;
      modem_ctrl <= 6'h00;
      scratch_field <= 5'h00;
      fifo_en <= 1'b0;
      rx_trig <= 2'h0;
      divisor <= ULM_DIVISOR_RST;
      nine_bit <= 1'b0;
      prog_empty <= 1'b0;
    end else begin
      if (wr_line) begin
        line_ctrl[7:6] <= bus_in.wdata[7:6];
        line_ctrl[2:0] <= bus_in.wdata[2:0];
        if (!busy) begin
          line_ctrl[5:3] <= bus_in.wdata[5:3];
        end
      end
      if (wr_modem) begin
        modem_ctrl <= bus_in.wdata[5:0];
      end
      if (wr_scratch) begin
        scratch_field <= bus_in.wdata[7:3];
      end
      if (wr_fifo) begin
        fifo_en <= bus_in.wdata[ULM_FC_ENABLE];
        rx_trig <= bus_in.wdata[7:6];
      end
      if (wr_ext) begin
        divisor <= bus_in.wdata[15:0];
        nine_bit <= bus_in.wdata[ULM_EC_NINE_BIT];
        prog_empty <= bus_in.wdata[ULM_EC_PROG_EMPTY];
      end
    end
  end

  // ****************************************
  // Baud tick, sixteen per bit
  // ****************************************
  logic [15:0] baud_cnt;
  logic tick;
  // Divisor zero stops the line entirely
  always_ff @(posedge clk_in) begin
    if (!rstn_in || divisor == 16'h0000) begin
      baud_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (baud_cnt == divisor - 16'h0001);
      baud_cnt <= (baud_cnt == divisor - 16'h0001) ? 16'h0000 : baud_cnt + 16'h0001;
    end
  end

  // ****************************************
  // Transmit FIFO and shifter
  // ****************************************
  logic [8:0] tx_mem [16];
  logic [3:0] tx_wp;
  logic [3:0] tx_rp;
  logic [4:0] tx_cnt;
  ulm_tx_state_t tx_state;
  logic [8:0] tx_shift;
  logic [3:0] tx_bit;
  logic [5:0] tx_sub;
  logic tx_line;

  wire [4:0] depth_lim = fifo_en ? ULM_FIFO_DEPTH : 5'h01;
  wire tx_full = (tx_cnt >= depth_lim);
  wire tx_load = (tx_state == TX_IDLE) && (tx_cnt != 5'h00) && tick;
  wire tx_push = wr_data && (!tx_full || !fifo_en);
  wire tx_over = wr_data && tx_full && !fifo_en && !tx_load;
  wire tx_rst = !rstn_in || fifo_en_change || (wr_fifo && bus_in.wdata[ULM_FC_TX_RESET]);
  wire tx_bit_end = tick && (tx_sub == ULM_BIT_TICKS - 6'h01);

  // Holding register is overwritten rather than queued without FIFOs
  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[tx_over ? tx_rp : tx_wp] <= bus_in.wdata[8:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (tx_rst) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_cnt <= 5'h00;
    end else begin
      if (tx_push && !tx_over) begin
        tx_wp <= fifo_en ? tx_wp + 4'h1 : 4'h0;
      end
      if (tx_load) begin
        tx_rp <= fifo_en ? tx_rp + 4'h1 : 4'h0;
      end
      tx_cnt <= tx_cnt + {4'h0, tx_push && !tx_over} - {4'h0, tx_load};
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tx_state <= TX_IDLE;
      tx_shift <= 9'h000;
      tx_bit <= 4'h0;
      tx_sub <= 6'h00;
      tx_line <= 1'b1;
    end else begin
      if (tick && tx_state != TX_IDLE) begin
        tx_sub <= tx_sub + 6'h01;
      end
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_shift <= tx_mem[tx_rp];
            tx_state <= TX_START;
            tx_sub <= 6'h00;
            tx_line <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state <= TX_DATA;
            tx_sub <= 6'h00;
            tx_bit <= 4'h0;
            tx_line <= tx_shift[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_sub <= 6'h00;
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit + 4'h1 < nbits) begin
              tx_line <= tx_shift[tx_bit + 4'h1];
            end else if (parity_enable && !nine_bit) begin
              tx_state <= TX_PAR;
              tx_line <= par_of(tx_shift, nbits, even_select, fixed_parity);
            end else begin
              tx_state <= TX_STOP;
              tx_line <= 1'b1;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_state <= TX_STOP;
            tx_sub <= 6'h00;
            tx_line <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tick && tx_sub == stop_ticks - 6'h01) begin
            tx_state <= TX_IDLE;
            tx_sub <= 6'h00;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  ulm_rx_state_t rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_bit;
  logic [5:0] rx_sub;
  logic rx_pe;
  logic rx_allzero;
  logic rx_push;
  ulm_rx_entry_t rx_new;

  // Loopback path also carries break so receive self-test sees it
  wire rx_line = loopback_ctrl ? (tx_line && !break_ctrl) : sin_in;
  wire rx_mid = tick && (rx_sub == ULM_BIT_TICKS - 6'h01);
  wire rx_par_bit = par_of(rx_shift, nbits, even_select, fixed_parity);

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_bit <= 4'h0;
      rx_sub <= 6'h00;
      rx_pe <= 1'b0;
      rx_allzero <= 1'b0;
      rx_push <= 1'b0;
      rx_new <= '0;
    end else begin
      rx_push <= 1'b0;
      if (tick) begin
        rx_sub <= rx_sub + 6'h01;
      end
      unique case (rx_state)
        RX_IDLE: begin
          rx_sub <= 6'h00;
          if (tick && !rx_line) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick && rx_sub == ULM_MID_TICK) begin
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
            rx_sub <= 6'h00;
            rx_bit <= 4'h0;
            rx_shift <= 9'h000;
            rx_pe <= 1'b0;
            rx_allzero <= 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sub <= 6'h00;
            rx_shift[rx_bit] <= rx_line;
            rx_allzero <= rx_allzero && !rx_line;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit + 4'h1 >= nbits) begin
              rx_state <= (parity_enable && !nine_bit) ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_mid) begin
            rx_sub <= 6'h00;
            rx_pe <= (rx_line != rx_par_bit);
            rx_allzero <= rx_allzero && !rx_line;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_sub <= 6'h00;
            rx_push <= 1'b1;
            rx_new.data <= rx_shift;
            rx_new.bi <= rx_allzero && !rx_line;
            rx_new.fe <= !rx_line;
            rx_new.pe <= rx_pe || (rx_allzero && !rx_line);
            if (rx_line) begin
              rx_state <= RX_IDLE;
            end else if (rx_allzero) begin
              rx_state <= RX_BRK; // wait for the line to go idle
            end else begin
              rx_state <= RX_DATA;
              rx_bit <= 4'h0;
              rx_shift <= 9'h000;
              rx_pe <= 1'b0;
              rx_allzero <= 1'b1;
            end
          end
        end
        RX_BRK: begin
          if (tick && rx_line) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Receive FIFO
  // ****************************************
  ulm_rx_entry_t rx_mem [16];
  logic [3:0] rx_wp;
  logic [3:0] rx_rp;
  logic [4:0] rx_cnt;
  logic [15:0] rx_err_vec;

  wire rx_full = (rx_cnt >= depth_lim);
  wire rx_pop = rd_data && (rx_cnt != 5'h00);
  wire rx_over = rx_push && rx_full && !rx_pop;
  wire rx_take = rx_push && (!rx_full || rx_pop || !fifo_en);
  wire rx_rewrite = rx_over && !fifo_en;
  wire rx_rst = !rstn_in || fifo_en_change || (wr_fifo && bus_in.wdata[ULM_FC_RX_RESET]);
  wire [3:0] rx_rp_next = rx_rp + 4'h1;
  // A new head appears on entry into an empty buffer, an overwrite or a pop
  wire head_from_push = rx_take && ((rx_cnt == 5'h00) || rx_rewrite || (rx_pop && rx_cnt == 5'h01));
  wire head_from_pop = rx_pop && (rx_cnt > 5'h01);
  wire ulm_rx_entry_t head_new = head_from_push ? rx_new : rx_mem[rx_rp_next];
  wire head_event = head_from_push || head_from_pop;
  wire [4:0] rx_trig_level = (rx_trig == 2'h0) ? 5'h01 : (rx_trig == 2'h1) ? 5'h04 :
                             (rx_trig == 2'h2) ? 5'h08 : 5'h0e;

  // Non-FIFO overrun replaces the held character in place
  always_ff @(posedge clk_in) begin
    if (rx_take) begin
      rx_mem[rx_rewrite ? rx_rp : rx_wp] <= rx_new;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rx_rst) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_cnt <= 5'h00;
    end else begin
      if (rx_take && !rx_rewrite) begin
        rx_wp <= fifo_en ? rx_wp + 4'h1 : 4'h0;
      end
      if (rx_pop) begin
        rx_rp <= fifo_en ? rx_rp_next : 4'h0;
      end
      rx_cnt <= rx_cnt + {4'h0, rx_take && !rx_rewrite} - {4'h0, rx_pop};
    end
  end

  // Error tag per live entry
  for (genvar i = 0; i < 16; i++) begin : g_rx_err
    wire [3:0] rel = 4'(i) - rx_rp;
    assign rx_err_vec[i] = ({1'b0, rel} < rx_cnt) && (rx_mem[i].pe || rx_mem[i].fe || rx_mem[i].bi);
  end

  // ****************************************
  // Line status flags
  // ****************************************
  logic overrun_flag;
  logic parity_error_flag;
  logic framing_error_flag;
  logic break_seen_flag;
  logic address_char_flag;

  // A status read clears; an event in the same cycle wins
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      break_seen_flag <= 1'b0;
      address_char_flag <= 1'b0;
    end else begin
      overrun_flag <= (overrun_flag && !rd_lstat) || rx_over;
      parity_error_flag <= (parity_error_flag && !rd_lstat) || (head_event && head_new.pe);
      framing_error_flag <= (framing_error_flag && !rd_lstat) || (head_event && head_new.fe);
      break_seen_flag <= (break_seen_flag && !rd_lstat) || (head_event && head_new.bi);
      address_char_flag <= (address_char_flag && !rd_lstat) || (nine_bit && head_event && head_new.data[8]);
    end
  end

  assign busy = (tx_state != TX_IDLE) || (rx_state != RX_IDLE) || (tx_cnt != 5'h00);
  wire data_ready_flag = (rx_cnt != 5'h00);
  wire rx_fifo_error_flag = fifo_en && (rx_err_vec != 16'h0000);
  wire tx_all_empty_flag = (tx_cnt == 5'h00) && (tx_state == TX_IDLE);
  wire tx_holding_empty_flag = (prog_empty && fifo_en) ? tx_full : (tx_cnt == 5'h00);

  // ****************************************
  // Modem status and pins
  // ****************************************
  logic cts_stat;
  logic cts_prev;
  logic clear_to_send_change;
  // Loopback takes the request field instead of the pin
  wire cts_eff = loopback_ctrl ? rts_field : !cts_n_in;
  wire rx_above = auto_flow_on && (rx_cnt >= rx_trig_level);

  // cts_prev resets deasserted so an asserted pin flags a change after release
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cts_stat <= 1'b1;
      cts_prev <= 1'b0;
      clear_to_send_change <= 1'b0;
      sout_out <= 1'b1;
      rts_n_out <= 1'b1;
    end else begin
      cts_stat <= cts_eff;
      cts_prev <= cts_eff;
      clear_to_send_change <= (clear_to_send_change && !rd_mstat) || (cts_eff != cts_prev);
      sout_out <= loopback_ctrl || (tx_line && !break_ctrl);
      rts_n_out <= loopback_ctrl || !rts_field || rx_above;
    end
  end

  // ****************************************
  // Read data, valid the cycle after the strobe
  // ****************************************
  wire [31:0] lstat_word = {23'h0, address_char_flag, rx_fifo_error_flag, tx_all_empty_flag,
                            tx_holding_empty_flag, break_seen_flag, framing_error_flag,
                            parity_error_flag, overrun_flag, data_ready_flag};
  wire [31:0] read_word =
      (bus_in.addr == ULM_DATA_ADDR) ? {23'h0, rx_mem[rx_rp].data} :
      (bus_in.addr == ULM_FIFO_CTRL_ADDR) ? {24'h0, {2{fifo_en}}, 6'h01} :
      (bus_in.addr == ULM_LINE_CTRL_ADDR) ? {24'h0, line_ctrl} :
      (bus_in.addr == ULM_MODEM_CTRL_ADDR) ? {26'h0, modem_ctrl} :
      (bus_in.addr == ULM_LINE_STAT_ADDR) ? lstat_word :
      (bus_in.addr == ULM_MODEM_STAT_ADDR) ? {27'h0, cts_stat, 3'h0, clear_to_send_change} :
      (bus_in.addr == ULM_SCRATCH_ADDR) ? {24'h0, scratch_field, 3'h0} :
      (bus_in.addr == ULM_STATE_ADDR) ? {31'h0, busy} :
      (bus_in.addr == ULM_EXT_CTRL_ADDR) ? {14'h0, prog_empty, nine_bit, divisor} : 32'h0;

  // Unmapped reads and idle cycles return zero
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= bus_in.rd ? read_word : 32'h0;
    end
  end

endmodule : ulm_uart

`default_nettype wire

// ### rtl/ulm_pkg.sv
// Package for the UART line and modem control and status block
package ulm_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [31:0] ULM_DATA_ADDR = 32'h5002_0100;
  localparam logic [31:0] ULM_FIFO_CTRL_ADDR = 32'h5002_0108;
  localparam logic [31:0] ULM_LINE_CTRL_ADDR = 32'h5002_010c;
  localparam logic [31:0] ULM_MODEM_CTRL_ADDR = 32'h5002_0110;
  localparam logic [31:0] ULM_LINE_STAT_ADDR = 32'h5002_0114;
  localparam logic [31:0] ULM_MODEM_STAT_ADDR = 32'h5002_0118;
  localparam logic [31:0] ULM_SCRATCH_ADDR = 32'h5002_011c;
  localparam logic [31:0] ULM_STATE_ADDR = 32'h5002_017c;
  localparam logic [31:0] ULM_EXT_CTRL_ADDR = 32'h5002_0180;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ULM_LC_BREAK = 6;
  localparam int ULM_LC_FIXED_PAR = 5;
  localparam int ULM_LC_EVEN = 4;
  localparam int ULM_LC_PAR_EN = 3;
  localparam int ULM_LC_STOP = 2;
  localparam int ULM_MC_AUTO_FLOW = 5;
  localparam int ULM_MC_LOOPBACK = 4;
  localparam int ULM_MC_RTS = 1;
  localparam int ULM_FC_ENABLE = 0;
  localparam int ULM_FC_RX_RESET = 1;
  localparam int ULM_FC_TX_RESET = 2;
  localparam int ULM_EC_NINE_BIT = 16;
  localparam int ULM_EC_PROG_EMPTY = 17;

  // ****************************************
  // Reset values, sizes and timing
  // ****************************************
  localparam logic [15:0] ULM_DIVISOR_RST = 16'h0001;
  localparam logic [4:0] ULM_FIFO_DEPTH = 5'h10;
  localparam logic [5:0] ULM_BIT_TICKS = 6'h10;
  localparam logic [5:0] ULM_STOP15_TICKS = 6'h18;
  localparam logic [5:0] ULM_STOP2_TICKS = 6'h20;
  localparam logic [5:0] ULM_MID_TICK = 6'h07;

  // Bus request bundle
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ulm_bus_req_t;

  // One receive entry: error tags travel with the character
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [8:0] data;
  } ulm_rx_entry_t;

endpackage : ulm_pkg

// ### bench/ulm_uart_monitor.sv
// Port assertions for the UART line and modem block
`timescale 1ns/1ps
`default_nettype none
module ulm_uart_monitor
  import ulm_pkg::*;
(
  // Clock and bus
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ulm_pkg::ulm_bus_req_t bus_in,
  input wire logic [31:0] rdata_out,
  // Serial side
  input wire logic cts_n_in,
  input wire logic sout_out,
  input wire logic rts_n_out
);
  import ulm_pkg::*;
  logic [31:0] mc, lc;
  logic [3:0] cfg_age, cts_age;
  logic cts_q, mstat_seen;
  wire logic rd_ms = bus_in.rd && bus_in.addr == ULM_MODEM_STAT_ADDR;
  wire logic cfg_ok = cfg_age > 4'h3;
  wire logic cts_ok = cts_age > 4'h3;
  // Control mirrors; ages let registered outputs settle before judging
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mc <= '0;
      lc <= '0;
      cfg_age <= '0;
      cts_age <= '0;
      mstat_seen <= 1'b0;
    end else begin
      if (bus_in.wr && bus_in.addr == ULM_MODEM_CTRL_ADDR) mc <= bus_in.wdata;
      if (bus_in.wr && bus_in.addr == ULM_LINE_CTRL_ADDR) lc <= bus_in.wdata;
      cfg_age <= bus_in.wr ? 4'h0 : cfg_age + {3'h0, cfg_age != 4'hf};
      cts_age <= (cts_n_in != cts_q) ? 4'h0 : cts_age + {3'h0, cts_age != 4'hf};
      mstat_seen <= mstat_seen | rd_ms;
    end
    cts_q <= cts_n_in;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  a_rts_direct: assert property (cfg_ok && !mc[4] && !mc[5] |-> rts_n_out == !mc[1])
    else $error("rts_n does not follow the request field");
  a_loop_rts: assert property (cfg_ok && mc[4] |-> rts_n_out)
    else $error("rts_n low in loopback");
  a_loop_sout: assert property (cfg_ok && mc[4] |-> sout_out)
    else $error("serial output low in loopback");
  a_break_low: assert property (cfg_ok && lc[6] && !mc[4] |-> !sout_out)
    else $error("serial output not held low during break");
  a_cts_pin: assert property (rd_ms && cfg_ok && cts_ok && !mc[4] |=> rdata_out[4] == !$past(cts_n_in))
    else $error("clear-to-send bit not the inverse of the pin");
  a_cts_loop: assert property (rd_ms && cfg_ok && mc[4] |=> rdata_out[4] == $past(mc[1]))
    else $error("clear-to-send bit not the looped request field");
  a_delta_clear: assert property ((rd_ms && cfg_ok && cts_ok) ##2 (rd_ms && cfg_ok && cts_ok) |=> !rdata_out[0])
    else $error("change flag not cleared by status read");
  a_delta_reset: assert property (rd_ms && !mstat_seen && cts_ok && !cts_n_in |=> rdata_out[0])
    else $error("change flag missing after reset with handshake asserted");
endmodule : ulm_uart_monitor
bind ulm_uart ulm_uart_monitor u_ulm_uart_monitor(.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .cts_n_in(cts_n_in), .sout_out(sout_out), .rts_n_out(rts_n_out));
`default_nettype wire

// ### bench/ulm_peer.sv
// Far-end serial device: drives the receive line and clear-to-send
`timescale 1ns/1ps
`default_nettype none
module ulm_peer (
  // Clock
  input wire logic clk_in,
  // Line and handshake
  output logic sin_out,
  output logic cts_n_out
);
  // Idle mark; handshake starts asserted to exercise the reset case
  initial begin
    sin_out = 1'b1;
    cts_n_out = 1'b0;
  end
  // Whole bit times of 16 clocks, divisor left at one
  task automatic hold(input logic b, input int bits);
    @(posedge clk_in);
    sin_out <= b;
    repeat (bits * 16 - 1) @(posedge clk_in);
  endtask : hold
  // LSB first; p below zero drops parity; low stop plus lows makes a break
  task automatic send(input logic [7:0] v, input int n, input int p, input logic s, input int lows);
    hold(1'b0, 1);
    for (int i = 0; i < n; i++) hold(v[i], 1);
    if (p >= 0) hold(p[0], 1);
    hold(s, 1 + lows);
    hold(1'b1, 1);
  endtask : send
endmodule : ulm_peer
`default_nettype wire

// ### bench/ulm_uart_tb.sv
// Self-checking bench for the UART line and modem block
`timescale 1ns/1ps
`default_nettype none
module ulm_uart_tb;
  import ulm_pkg::*;
  logic clk_in, rstn_in, pend, stp, sin, cts_n, sout, rts_n;
  ulm_pkg::ulm_bus_req_t bus;
  logic [31:0] rdata;
  logic [63:0] q[$];
  logic [63:0] nt;
  logic [7:0] d, m;
  int error_cnt, samples_checked, cyc, k, p;
  ulm_uart u_ulm_uart(.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata), .sin_in(sin),
    .cts_n_in(cts_n), .sout_out(sout), .rts_n_out(rts_n));
  ulm_peer u_ulm_peer(.clk_in(clk_in), .sin_out(sin), .cts_n_out(cts_n));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Bus master: one-cycle strobes, expected read data queued at issue
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_in);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] msk);
    @(posedge clk_in);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    q.push_back({msk, e & msk});
    @(posedge clk_in);
    bus.rd <= 1'b0;
  endtask : rd
  // Read data stand one cycle only, so compare mid-cycle after the strobe
  always @(negedge clk_in) begin
    if (pend) begin
      nt = q.pop_front();
      samples_checked++;
      if ((rdata & nt[63:32]) !== nt[31:0]) begin
        error_cnt++;
        $display("mismatch rdata expected %h seen %h", nt[31:0], rdata & nt[63:32]);
      end
    end
    pend = bus.rd;
  end
  task automatic pin(input logic e);
    @(negedge clk_in);
    samples_checked++;
    if (rts_n !== e) begin
      error_cnt++;
      $display("mismatch rts_n expected %b seen %b", e, rts_n);
    end
  endtask : pin
  // One character in, then status and data read back; low stop means break
  task automatic rx(input logic [7:0] v, input int n, input int pb, input logic s, input logic [31:0] ls);
    u_ulm_peer.send(v, n, pb, s, s ? 0 : 12);
    rd(ULM_LINE_STAT_ADDR, ls, 32'h1f);
    rd(ULM_DATA_ADDR, {24'h0, v}, 32'hff);
  endtask : rx
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Hang guard, far above the expected run length
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    bus = '0;
    rstn_in = 1'b0;
    pend = 1'b0;
    void'($urandom(32'h117c));
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(ULM_LINE_STAT_ADDR, 32'h60, 32'h1ff);
    rd(ULM_MODEM_STAT_ADDR, 32'h11, 32'h11);
    rd(ULM_MODEM_STAT_ADDR, 32'h10, 32'h11);
    rd(32'h5002_01f0, 32'h0, 32'hffff_ffff);
    d = 8'($urandom);
    wr(ULM_SCRATCH_ADDR, {24'h0, d});
    rd(ULM_SCRATCH_ADDR, {24'h0, d}, 32'hf8);
    u_ulm_peer.cts_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    rd(ULM_MODEM_STAT_ADDR, 32'h01, 32'h11);
    wr(ULM_FIFO_CTRL_ADDR, 32'h0);
    // Eight length, parity and fixed-parity combinations covering every length and parity mode; one bad parity
    for (k = 0; k < 8; k++) begin
      m = 8'((9'h20 << (k % 4)) - 1);
      d = 8'($urandom) & m;
      stp = 1'($urandom);
      p = k[2] ? int'(!k[1]) : int'(k[1] ? ^d : !(^d));
      if (k == 3) p = 1 - p;
      wr(ULM_LINE_CTRL_ADDR, 32'({k[2:0], stp, k[1:0]}));
      rx(d, 5 + k % 4, k[0] ? p : -1, 1'b1, k == 3 ? 32'h5 : 32'h1);
    end
    // Parity fields locked while a character is arriving
    fork
      rx(d, 8, 0, 1'b1, 32'h1);
      begin
        repeat (60) @(posedge clk_in);
        wr(ULM_LINE_CTRL_ADDR, 32'({3'b000, stp, 2'b11}));
      end
    join
    rd(ULM_LINE_CTRL_ADDR, 32'({3'b111, stp, 2'b11}), 32'h3f);
    wr(ULM_LINE_CTRL_ADDR, 32'h3);
    u_ulm_peer.send(8'h3c, 8, -1, 1'b1, 0);
    rx(8'hc3, 8, -1, 1'b1, 32'h3);
    u_ulm_peer.send(8'h5a, 8, -1, 1'b0, 0);
    u_ulm_peer.hold(1'b1, 12);
    rd(ULM_LINE_STAT_ADDR, 32'hb, 32'h1f);
    rd(ULM_DATA_ADDR, 32'hff, 32'hff);
    rx(8'h00, 8, -1, 1'b0, 32'h1d);
    rd(ULM_LINE_STAT_ADDR, 32'h0, 32'h1f);
    wr(ULM_MODEM_CTRL_ADDR, 32'h2);
    wr(ULM_LINE_CTRL_ADDR, 32'h43);
    repeat (6) @(posedge clk_in);
    wr(ULM_LINE_CTRL_ADDR, 32'h3);
    wr(ULM_MODEM_CTRL_ADDR, 32'h12);
    repeat (5) @(posedge clk_in);
    rd(ULM_MODEM_STAT_ADDR, 32'h10, 32'h10);
    d = 8'($urandom);
    wr(ULM_DATA_ADDR, {24'h0, d});
    repeat (400) @(posedge clk_in);
    rd(ULM_LINE_STAT_ADDR, 32'h61, 32'h7f);
    rd(ULM_DATA_ADDR, {24'h0, d}, 32'hff);
    // Automatic flow control with a one-character trigger
    wr(ULM_FIFO_CTRL_ADDR, 32'h1);
    wr(ULM_MODEM_CTRL_ADDR, 32'h22);
    u_ulm_peer.send(d, 8, -1, 1'b1, 0);
    pin(1'b1);
    rd(ULM_DATA_ADDR, {24'h0, d}, 32'hff);
    repeat (4) @(posedge clk_in);
    pin(1'b0);
    wr(ULM_EXT_CTRL_ADDR, 32'h0002_0001);
    rd(ULM_LINE_STAT_ADDR, 32'h40, 32'hff);
    u_ulm_peer.send(8'h00, 8, -1, 1'b0, 12);
    rd(ULM_LINE_STAT_ADDR, 32'hdd, 32'hff);
    give_verdict();
  end
endmodule : ulm_uart_tb
`default_nettype wire
